// *** include/iowd_pkg.sv ***
/*
 * constants for the i/o hub supervisory countdown: config ports,
 * register indices, field positions, reset values and timing.
 * assumes a single 125 mhz clock shared with the host i/o logic.
 */
package iowd_pkg;

   // host i/o port addresses
   localparam logic [15:0] IOWD_IDX_PORT   = 16'h002e;
   localparam logic [15:0] IOWD_DATA_PORT  = 16'h002f;

   // configuration unlock / lock keys
   localparam logic [7:0]  IOWD_UNLOCK_KEY = 8'h87;
   localparam logic [7:0]  IOWD_LOCK_KEY   = 8'haa;

   // register indices
   localparam logic [7:0]  IOWD_IDX_LDN    = 8'h07;
   localparam logic [7:0]  IOWD_IDX_ENABLE = 8'h30;
   localparam logic [7:0]  IOWD_IDX_ACT    = 8'hf0;
   localparam logic [7:0]  IOWD_IDX_TBASE  = 8'hf5;
   localparam logic [7:0]  IOWD_IDX_COUNT  = 8'hf6;

   // logical device number of the countdown block
   localparam logic [7:0]  IOWD_LDN_SELF   = 8'h07;

   // field positions
   localparam int          IOWD_ENABLE_BIT = 0;
   localparam int          IOWD_ACT_BIT    = 7;
   localparam int          IOWD_MINUTE_BIT = 3;

   // reset values
   localparam logic [7:0]  IOWD_LDN_RST    = 8'h00;
   localparam logic [7:0]  IOWD_ENABLE_RST = 8'h00;
   localparam logic [7:0]  IOWD_ACT_RST    = 8'h00;
   localparam logic [7:0]  IOWD_TBASE_RST  = 8'h71;
   localparam logic [7:0]  IOWD_COUNT_RST  = 8'h00;
   localparam logic [7:0]  IOWD_IDX_RST    = 8'h00;

   // read answers
   localparam logic [7:0]  IOWD_RD_LOCKED  = 8'hff;
   localparam logic [7:0]  IOWD_RD_UNMAP   = 8'h00;

   // count limits
   localparam logic [7:0]  IOWD_COUNT_OFF  = 8'h00;
   localparam logic [7:0]  IOWD_COUNT_LAST = 8'h01;
   localparam logic [7:0]  IOWD_COUNT_STEP = 8'h01;

   // timing
   localparam longint      IOWD_CLK_HZ         = 125_000_000;
   localparam longint      IOWD_CLK_PERIOD_NS  = 8;
   localparam longint      IOWD_TICK_PERIOD_S  = 1;
   localparam int          IOWD_CYC_PER_SEC    = int'(IOWD_TICK_PERIOD_S * IOWD_CLK_HZ);
   localparam int          IOWD_SECS_PER_MIN   = 60;
   localparam longint      IOWD_REBOOT_PULSE_NS = 128;
   localparam int          IOWD_REBOOT_CYC     =
      int'(IOWD_REBOOT_PULSE_NS / IOWD_CLK_PERIOD_NS);

   typedef enum logic [1:0] {
      IOWD_LOCKED,
      IOWD_HALF_OPEN,
      IOWD_UNLOCKED
   } iowd_lock_t;

endpackage : iowd_pkg

// *** core/iowd_tick_gen.sv ***
/*
 * time base for the countdown: one-cycle tick per second or per minute.
 * assumes i_restart clears the phase so a fresh load gets a full unit.
 */
`timescale 1ns/1ps
module iowd_tick_gen
   import iowd_pkg::*;
#(
   parameter int CYC_PER_SEC = IOWD_CYC_PER_SEC
)
(
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   // control
   input  wire logic i_run,
   input  wire logic i_restart,
   input  wire logic i_minutes,
   // tick out
   output logic      o_tick
);

   logic [31:0] cyc_reg;
   logic [5:0]  sec_reg;
   logic        sec_end;
   logic        min_end;

   assign sec_end = (cyc_reg == 32'(CYC_PER_SEC - 1));
   assign min_end = (sec_reg == 6'(IOWD_SECS_PER_MIN - 1));

   // cycle prescaler
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         cyc_reg <= '0;
      else if (i_restart || !i_run || sec_end)
         cyc_reg <= '0;
      else
         cyc_reg <= cyc_reg + 32'h1;
   end

   // seconds within a minute
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         sec_reg <= '0;
      else if (i_restart || !i_run)
         sec_reg <= '0;
      else if (sec_end)
         sec_reg <= min_end ? 6'h0 : sec_reg + 6'h1;
   end

   // tick pulse
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_tick <= 1'b0;
      else
         o_tick <= i_run && !i_restart && sec_end && (!i_minutes || min_end);
   end

endmodule : iowd_tick_gen

// *** core/iowd_top.sv ***
/*
 * supervisory countdown inside the i/o hub, reached through the
 * index/data configuration port pair. holds the unlock sequence,
 * the config registers and the countdown that asks for a reboot.
 * assumes host i/o strobes come from logic on the same clock.
 */
`timescale 1ns/1ps

// Notes on behaviour
// R1 - countdown is an 8-bit field giving levels 1 to 255
// R2 - once loaded and enabled, counting runs with no further host action
// R3 - reaching zero raises a system reboot request
// R4 - host must reload or disable before zero to avoid reboot
// R5 - unlock by 87 twice to 2E, select device 07, enable 30, activate F0
// R6 - index F6 sets timeout; 00 disables, nonzero gives units before expiry
// R7 - seconds base with count FFh expires after 255 seconds
// R8 - writing 71h to index F5 selects the one-second time base
// R9 - writing 79h to index F5 selects the one-minute time base
// R10 - host should load a count longer than the supervised task runtime
// R11 - count drops by one per tick; a new write restarts from that value
module iowd_top
   import iowd_pkg::*;
#(
   parameter int CYC_PER_SEC = IOWD_CYC_PER_SEC
)
(
   // clock and reset
   input  wire logic        I_CLK,
   input  wire logic        I_RST_N,
   // host i/o port access
   input  wire logic [15:0] I_IO_ADDR,
   input  wire logic [7:0]  I_IO_WDATA,
   input  wire logic        I_IO_WR,
   input  wire logic        I_IO_RD,
   output logic [7:0]       O_IO_RDATA,
   output logic             O_IO_RVALID,
   // status and system control
   output logic             O_CFG_UNLOCKED,
   output logic             O_COUNT_RUNNING,
   output logic             O_SYS_REBOOT
);

   // port decode
   logic        idx_wr;
   logic        data_wr;
   logic        data_rd;
   logic        self_sel;
   logic        cfg_wr;
   logic        enable_wr;
   logic        act_wr;
   logic        tbase_wr;

   // config state
   iowd_lock_t  lock_reg;
   iowd_lock_t  lock_next;
   logic [7:0]  index_reg;
   logic [7:0]  ldn_reg;
   logic [7:0]  enable_reg;
   logic [7:0]  act_reg;
   logic [7:0]  tbase_reg;
   logic [7:0]  enable_next;
   logic [7:0]  act_next;

   // countdown
   logic [7:0]  count_reg;
   logic [7:0]  count_next;
   logic        count_load;
   logic        active;
   logic        running;
   logic        tick;
   logic        expire;
   logic [7:0]  reboot_cnt_reg;

   // read path
   logic [7:0]  rd_mux;

   function automatic logic hits(input logic [7:0] idx, input logic [7:0] reg_idx);
      hits = (idx == reg_idx);
   endfunction : hits

   assign idx_wr   = I_IO_WR && (I_IO_ADDR == IOWD_IDX_PORT);
   assign data_wr  = I_IO_WR && (I_IO_ADDR == IOWD_DATA_PORT);
   assign data_rd  = I_IO_RD && (I_IO_ADDR == IOWD_DATA_PORT);
   assign self_sel = (ldn_reg == IOWD_LDN_SELF);
   assign cfg_wr   = data_wr && (lock_reg == IOWD_UNLOCKED);

   // per-register write strobes, only for the selected device
   assign enable_wr = cfg_wr && self_sel && hits(index_reg, IOWD_IDX_ENABLE);
   assign act_wr    = cfg_wr && self_sel && hits(index_reg, IOWD_IDX_ACT);
   assign tbase_wr  = cfg_wr && self_sel && hits(index_reg, IOWD_IDX_TBASE);

   // unlock sequence: two key writes on the index port with no other port write between
   always_comb
   begin
      lock_next = lock_reg;
      if (idx_wr)
      begin
         case (lock_reg)
            IOWD_LOCKED:
               lock_next = (I_IO_WDATA == IOWD_UNLOCK_KEY) ? IOWD_HALF_OPEN
                                                           : IOWD_LOCKED; // [R5]
            IOWD_HALF_OPEN:
               lock_next = (I_IO_WDATA == IOWD_UNLOCK_KEY) ? IOWD_UNLOCKED
                                                           : IOWD_LOCKED; // [R5]
            IOWD_UNLOCKED:
               lock_next = (I_IO_WDATA == IOWD_LOCK_KEY) ? IOWD_LOCKED
                                                         : IOWD_UNLOCKED;
            default:
               lock_next = IOWD_LOCKED;
         endcase
      end
      else if (data_wr && (lock_reg == IOWD_HALF_OPEN))
      begin
         lock_next = IOWD_LOCKED;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         lock_reg <= IOWD_LOCKED;
      else
         lock_reg <= lock_next;
   end

   // index latch, only while unlocked
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         index_reg <= IOWD_IDX_RST;
      else if (idx_wr && (lock_reg == IOWD_UNLOCKED) && (I_IO_WDATA != IOWD_LOCK_KEY))
         index_reg <= I_IO_WDATA; // [R5]
   end

   // logical device select is global
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         ldn_reg <= IOWD_LDN_RST;
      else if (cfg_wr && hits(index_reg, IOWD_IDX_LDN))
         ldn_reg <= I_IO_WDATA; // [R5]
   end

   // device enable
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         enable_reg <= IOWD_ENABLE_RST;
      else if (enable_wr)
         enable_reg <= I_IO_WDATA; // [R5]
   end

   // activate
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         act_reg <= IOWD_ACT_RST;
      else if (act_wr)
         act_reg <= I_IO_WDATA; // [R5]
   end

   // time base select: 71h seconds, 79h minutes
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         tbase_reg <= IOWD_TBASE_RST;
      else if (tbase_wr)
         tbase_reg <= I_IO_WDATA; // [R8] [R9]
   end

   // enable and activate as they stand after this edge, for the status flag
   always_comb
   begin
      enable_next = enable_reg;
      act_next    = act_reg;
      if (enable_wr)
         enable_next = I_IO_WDATA;
      if (act_wr)
         act_next = I_IO_WDATA;
   end

   assign count_load = cfg_wr && self_sel && hits(index_reg, IOWD_IDX_COUNT);

   // device must be both enabled and activated
   assign active  = enable_reg[IOWD_ENABLE_BIT] && act_reg[IOWD_ACT_BIT]; // [R5]
   assign running = active && (count_reg != IOWD_COUNT_OFF); // [R2] [R6]

   // prescaler phase restarts on every load so each reload gets a full unit
   iowd_tick_gen #(
      .CYC_PER_SEC (CYC_PER_SEC)
   ) u_tick (
      .i_clk     (I_CLK),
      .i_rst_n   (I_RST_N),
      .i_run     (running),
      .i_restart (count_load), // [R11]
      .i_minutes (tbase_reg[IOWD_MINUTE_BIT]), // [R7] [R8] [R9]
      .o_tick    (tick)
   );

   // a reload in the tick cycle cancels the expiry
   assign expire = tick && running && !count_load && (count_reg == IOWD_COUNT_LAST); // [R3]

   // countdown: a host write wins over a tick in the same cycle
   always_comb
   begin
      count_next = count_reg;
      if (count_load)
         count_next = I_IO_WDATA; // [R1] [R6] [R11]
      else if (tick && running)
         count_next = count_reg - IOWD_COUNT_STEP; // [R2] [R11]
   end

   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         count_reg <= IOWD_COUNT_RST;
      else
         count_reg <= count_next;
   end

   // reboot request stretched to a fixed width
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         reboot_cnt_reg <= '0;
      else if (expire)
         reboot_cnt_reg <= 8'(IOWD_REBOOT_CYC); // [R3]
      else if (reboot_cnt_reg != 8'h0)
         reboot_cnt_reg <= reboot_cnt_reg - 8'h1;
   end

   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         O_SYS_REBOOT <= 1'b0;
      else
         O_SYS_REBOOT <= expire || (reboot_cnt_reg > 8'h1); // [R3]
   end

   // data port read mux; count reads back the live remaining value
   always_comb
   begin
      rd_mux = IOWD_RD_UNMAP;
      if (lock_reg != IOWD_UNLOCKED)
         rd_mux = IOWD_RD_LOCKED;
      else if (hits(index_reg, IOWD_IDX_LDN))
         rd_mux = ldn_reg;
      else if (self_sel)
      begin
         case (index_reg)
            IOWD_IDX_ENABLE: rd_mux = enable_reg;
            IOWD_IDX_ACT:    rd_mux = act_reg;
            IOWD_IDX_TBASE:  rd_mux = tbase_reg;
            IOWD_IDX_COUNT:  rd_mux = count_reg;
            default:         rd_mux = IOWD_RD_UNMAP;
         endcase
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         O_IO_RDATA <= '0;
      else if (data_rd)
         O_IO_RDATA <= rd_mux;
   end

   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         O_IO_RVALID <= 1'b0;
      else
         O_IO_RVALID <= data_rd;
   end

   // status
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         O_CFG_UNLOCKED <= 1'b0;
      else
         O_CFG_UNLOCKED <= (lock_next == IOWD_UNLOCKED);
   end

   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         O_COUNT_RUNNING <= 1'b0;
      else
         O_COUNT_RUNNING <= enable_next[IOWD_ENABLE_BIT] && act_next[IOWD_ACT_BIT]
                            && (count_next != IOWD_COUNT_OFF); // [R2]
   end

endmodule : iowd_top

// *** verification/iowd_top_asserts.sv ***
/* port checker for the countdown top
   assumes one clock and an async low reset */
`timescale 1ns/1ps
module iowd_top_asserts
   import iowd_pkg::*;
#(
   parameter int CYC_PER_SEC = IOWD_CYC_PER_SEC
)
(
   // clock and reset
   input wire logic        I_CLK,
   input wire logic        I_RST_N,
   // host port
   input wire logic [15:0] I_IO_ADDR,
   input wire logic [7:0]  I_IO_WDATA,
   input wire logic        I_IO_WR,
   input wire logic        I_IO_RD,
   input wire logic [7:0]  O_IO_RDATA,
   input wire logic        O_IO_RVALID,
   // status
   input wire logic        O_CFG_UNLOCKED,
   input wire logic        O_COUNT_RUNNING,
   input wire logic        O_SYS_REBOOT
);
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_N);
   logic drd;
   logic key;
   int   run_cnt;
   assign drd = I_IO_RD && I_IO_ADDR == IOWD_DATA_PORT;
   assign key = I_IO_WR && I_IO_ADDR == IOWD_IDX_PORT && I_IO_WDATA == IOWD_UNLOCK_KEY;
   // unbroken running cycles
   always_ff @(posedge I_CLK or negedge I_RST_N)
      if (!I_RST_N)
         run_cnt <= 0;
      else
         run_cnt <= O_COUNT_RUNNING ? run_cnt + 1 : 0;
   AST_RVALID: assert property (drd |=> O_IO_RVALID)
      else $error("read not answered");
   AST_NORV: assert property (!drd |=> !O_IO_RVALID)
      else $error("stray answer");
   AST_RDHOLD: assert property (!O_IO_RVALID |-> $stable(O_IO_RDATA))
      else $error("read data moved");
   AST_LOCKRD: assert property (drd && !O_CFG_UNLOCKED |=> O_IO_RDATA == IOWD_RD_LOCKED)
      else $error("locked read wrong");
   AST_UNLK: assert property (key ##1 key |=> O_CFG_UNLOCKED)
      else $error("keys did not unlock");
   AST_UNLK_SRC: assert property ($rose(O_CFG_UNLOCKED) |-> $past(key))
      else $error("unlock without key");
   AST_EXPIRE: assert property ($rose(O_SYS_REBOOT) |->
      $past(O_COUNT_RUNNING) && !O_COUNT_RUNNING)
      else $error("reboot without expiry");
   AST_PULSE: assert property ($rose(O_SYS_REBOOT) |->
      O_SYS_REBOOT[*8] ##1 O_SYS_REBOOT[*8] ##1 !O_SYS_REBOOT)
      else $error("reboot width wrong");
   AST_MINTIME: assert property ($rose(O_SYS_REBOOT) |-> run_cnt >= CYC_PER_SEC)
      else $error("expiry too early");
   cover property (key ##1 key);
   cover property ($rose(O_SYS_REBOOT));
   cover property ($fell(O_COUNT_RUNNING) && !O_SYS_REBOOT);
endmodule : iowd_top_asserts

bind iowd_top iowd_top_asserts #(.CYC_PER_SEC(CYC_PER_SEC)) chk_u (.I_CLK, .I_RST_N,
   .I_IO_ADDR, .I_IO_WDATA, .I_IO_WR, .I_IO_RD, .O_IO_RDATA, .O_IO_RVALID,
   .O_CFG_UNLOCKED, .O_COUNT_RUNNING, .O_SYS_REBOOT);

// *** verification/iowd_host_model.sv ***
/* host side of the config port pair
   assumes tasks start 1 ns after a rising edge */
`timescale 1ns/1ps
module iowd_host_model
   import iowd_pkg::*;
(
   // clock
   input  wire logic       i_clk,
   // port cycles
   output logic [15:0]     o_addr,
   output logic [7:0]      o_wdata,
   output logic            o_wr,
   output logic            o_rd,
   input  wire logic [7:0] i_rdata,
   input  wire logic       i_rvalid
);
   initial
   begin
      o_addr = 16'h0000;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   // strobe held so writes run back to back
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      o_wr = 1'b1;
      o_addr = a;
      o_wdata = d;
      @(posedge i_clk);
      #1;
   endtask : wr
   // released lines show the inverse
   task automatic idle();
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = ~o_addr;
      o_wdata = ~o_wdata;
      @(posedge i_clk);
      #1;
   endtask : idle
   task automatic unlock();
      wr(IOWD_IDX_PORT, IOWD_UNLOCK_KEY);
      wr(IOWD_IDX_PORT, IOWD_UNLOCK_KEY);
      idle();
   endtask : unlock
   task automatic wr_reg(input logic [7:0] i, input logic [7:0] d);
      wr(IOWD_IDX_PORT, i);
      wr(IOWD_DATA_PORT, d);
      idle();
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] i, output logic [7:0] d);
      wr(IOWD_IDX_PORT, i);
      o_wr = 1'b0;
      o_rd = 1'b1;
      o_addr = IOWD_DATA_PORT;
      @(posedge i_clk);
      #1;
      d = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
      idle();
   endtask : rd_reg
endmodule : iowd_host_model

// *** verification/io_hub_watchdog_timer_test.sv ***
/* bench for the countdown: host model drives the ports,
   an integer model predicts reads and expiry windows */
`timescale 1ns/1ps
module io_hub_watchdog_timer_test;
   import iowd_pkg::*;
   localparam int CPS = 4;
   logic        clk, rst_n, wr, rd, rvalid, unl, run, boot, boot_seen, m_unl;
   logic [15:0] addr;
   logic [7:0]  wdata, rdata, got, m_ldn;
   logic [7:0]  mdl[int];
   logic [7:0]  idxs[6];
   logic [7:0]  tb_base[3];
   int          tb_cnt[3];
   int          err_total, check_count, cyc, n;

   iowd_top #(.CYC_PER_SEC(CPS)) dut_u (.I_CLK(clk), .I_RST_N(rst_n), .I_IO_ADDR(addr),
      .I_IO_WDATA(wdata), .I_IO_WR(wr), .I_IO_RD(rd), .O_IO_RDATA(rdata),
      .O_IO_RVALID(rvalid), .O_CFG_UNLOCKED(unl), .O_COUNT_RUNNING(run),
      .O_SYS_REBOOT(boot));
   iowd_host_model host_u (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
      .o_rd(rd), .i_rdata(rdata), .i_rvalid(rvalid));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (boot === 1'b1)
         boot_seen = 1'b1;
      if (cyc == 30000)
      begin
         err_total++;
         end_of_test();
      end
   end

   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk8
   task automatic chk1(input logic g, input logic e);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED %0t: flag %b exp %b", $time, g, e);
      end
   endtask : chk1
   task automatic chkrng(input int g, input int lo, input int hi);
      check_count++;
      if (g < lo || g > hi)
      begin
         err_total++;
         $display("CHECK FAILED %0t: %0d cycles not in %0d..%0d", $time, g, lo, hi);
      end
   endtask : chkrng
   task automatic end_of_test();
      if (err_total == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   function automatic logic [7:0] mexp(input logic [7:0] i);
      if (!m_unl)
         return IOWD_RD_LOCKED;
      if (i == IOWD_IDX_LDN)
         return m_ldn;
      if (m_ldn != IOWD_LDN_SELF || !mdl.exists(i))
         return IOWD_RD_UNMAP;
      return mdl[i];
   endfunction : mexp
   task automatic mwr(input logic [7:0] i, input logic [7:0] d);
      host_u.wr_reg(i, d);
      if (m_unl && i == IOWD_IDX_LDN)
         m_ldn = d;
      else if (m_unl && m_ldn == IOWD_LDN_SELF && mdl.exists(i))
         mdl[i] = d;
   endtask : mwr
   task automatic mrd(input logic [7:0] i);
      host_u.rd_reg(i, got);
      chk8(got, mexp(i));
   endtask : mrd
   task automatic wait_cyc(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask : wait_cyc
   // cycles from load edge to reboot: CPS per unit plus the tick register
   task automatic expire(input int u);
      n = 1;
      while (boot !== 1'b1 && n < u * CPS + 8)
         wait_cyc(1);
      chkrng(n, u * CPS, u * CPS + 2);
   endtask : expire

   always @(posedge clk)
      if (n > 0 && boot !== 1'b1)
         n++;

   initial
   begin
      rst_n = 1'b0;
      boot_seen = 1'b0;
      m_unl = 1'b0;
      n = 0;
      m_ldn = IOWD_LDN_RST;
      mdl[IOWD_IDX_ENABLE] = IOWD_ENABLE_RST;
      mdl[IOWD_IDX_ACT] = IOWD_ACT_RST;
      mdl[IOWD_IDX_TBASE] = IOWD_TBASE_RST;
      mdl[IOWD_IDX_COUNT] = IOWD_COUNT_RST;
      idxs = '{IOWD_IDX_LDN, IOWD_IDX_ENABLE, IOWD_IDX_ACT, IOWD_IDX_TBASE, IOWD_IDX_COUNT, 8'h55};
      tb_base = '{8'h71, 8'h71, 8'h79};
      void'($urandom(32'hc17b6147));
      tb_cnt = '{2 + $urandom % 4, 255, 1};
      wait_cyc(20);
      rst_n = 1'b1;
      mrd(IOWD_IDX_COUNT);
      chk1(unl, 1'b0);
      host_u.unlock();
      m_unl = 1'b1;
      chk1(unl, 1'b1);
      mwr(IOWD_IDX_COUNT, 8'h05);
      mrd(IOWD_IDX_TBASE);
      mwr(IOWD_IDX_LDN, IOWD_LDN_SELF);
      foreach (idxs[k])
         mrd(idxs[k]);
      mwr(IOWD_IDX_ENABLE, 8'h01);
      mwr(IOWD_IDX_ACT, 8'h80);
      chk1(run, 1'b0);
      foreach (tb_cnt[k])
      begin
         mwr(IOWD_IDX_TBASE, tb_base[k]);
         mwr(IOWD_IDX_COUNT, 8'(tb_cnt[k]));
         n = 1;
         chk1(run, 1'b1);
         expire(tb_base[k] == 8'h79 ? 60 * tb_cnt[k] : tb_cnt[k]);
         n = 0;
         chk1(run, 1'b0);
         mdl[IOWD_IDX_COUNT] = 8'h00;
         mrd(IOWD_IDX_COUNT);
         wait_cyc(20);
      end
      boot_seen = 1'b0;
      mwr(IOWD_IDX_TBASE, IOWD_TBASE_RST);
      repeat (8)
         mwr(IOWD_IDX_COUNT, 8'h02);
      mwr(IOWD_IDX_COUNT, 8'h05);
      wait_cyc(2 * CPS + 1);
      mdl[IOWD_IDX_COUNT] = 8'h03;
      mrd(IOWD_IDX_COUNT);
      mwr(IOWD_IDX_COUNT, 8'h00);
      chk1(run, 1'b0);
      mwr(IOWD_IDX_COUNT, 8'h02);
      host_u.wr(IOWD_IDX_PORT, IOWD_IDX_ENABLE);
      host_u.wr(IOWD_DATA_PORT, 8'h00);
      mdl[IOWD_IDX_ENABLE] = 8'h00;
      chk1(run, 1'b0);
      host_u.idle();
      wait_cyc(4 * CPS);
      chk1(boot_seen, 1'b0);
      host_u.wr(IOWD_IDX_PORT, IOWD_LOCK_KEY);
      host_u.idle();
      m_unl = 1'b0;
      chk1(unl, 1'b0);
      mrd(IOWD_IDX_ENABLE);
      end_of_test();
   end
endmodule : io_hub_watchdog_timer_test
